// *** hw/usb_power_control_pkg.sv ***
// constants for the usb power and suspend control block
package usb_power_control_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_MASK = 4'h8;

  // ********************************************************
  // control register fields
  // ********************************************************
  localparam int BIT_POWER = 0;
  localparam int BIT_SUSPEND = 1;
  localparam int BIT_NOT_READY = 3;
  localparam int BIT_GUARD = 4;
  localparam int BIT_ACT_PEND = 7;

  // ********************************************************
  // interrupt status and mask fields
  // ********************************************************
  localparam int EV_W = 2;
  localparam int EV_ACTIVITY = 0;
  localparam int EV_READY = 1;

  // ********************************************************
  // reset values and timing
  // ********************************************************
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] EV_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [3:0] SETTLE_RESET = 4'h0;
  // cycles after power-off before the module may be enabled again
  localparam logic [3:0] SETTLE_CYCLES = 4'h8;

endpackage

// *** hw/level_sync.sv ***
// two flip-flop synchroniser for one level from a pin
`timescale 1ns/1ps
module level_sync (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic din,
  output logic dout
);
  logic stage1;

  // first stage feeds only the second
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // level_sync

// *** hw/usb_power_control.sv ***
// usb power, suspend and sleep guard control with register port
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module usb_power_control (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [usb_power_control_pkg::ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic USB_ACTIVITY,
  output logic USB_CLK_EN,
  output logic XCVR_LOWPOWER,
  output logic PINS_OWNED,
  output logic ANALOG_EN,
  output logic SLEEP_BLOCK,
  output logic IRQ
);
  import usb_power_control_pkg::*;

  // ********************************************************
  // declarations
  // ********************************************************
  logic module_power_enable;
  logic suspend_request;
  logic sleep_entry_guard;
  logic activity_pending;
  logic module_not_ready;
  logic next_not_ready;
  logic [3:0] settle;
  logic act_sync;
  logic act_prev;
  logic act_edge;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] events;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic clk_run;

  // address match, used by both read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // control word as software sees it
  function automatic logic [31:0] ctrl_word(input logic pwr,
                                            input logic sus,
                                            input logic nrdy,
                                            input logic grd,
                                            input logic pend);
    logic [31:0] w;
    w = 32'h0000_0000; // unused bits stay zero
    w[BIT_POWER] = pwr;
    w[BIT_SUSPEND] = sus;
    w[BIT_NOT_READY] = nrdy;
    w[BIT_GUARD] = grd;
    w[BIT_ACT_PEND] = pend;
    ctrl_word = w;
  endfunction

  // ********************************************************
  // bus decode
  // ********************************************************

  // one-cycle strobes qualified by address
  assign wr_ctrl = WR && hit(ADDR, OFF_CTRL);
  assign wr_mask = WR && hit(ADDR, OFF_MASK);
  assign rd_stat = RD && hit(ADDR, OFF_STAT);

  // ********************************************************
  // activity input
  // ********************************************************

  // pin crosses two flops before use
  level_sync u_act_sync (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .din(USB_ACTIVITY),
    .dout(act_sync)
  );

  // previous synced level for edge detect
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_prev <= CTRL_RESET;
    end else begin
      act_prev <= act_sync;
    end
  end

  assign act_edge = act_sync && !act_prev;

  // ********************************************************
  // control bits written by software
  // ********************************************************

  // only bits 0, 1 and 4 take write data
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      module_power_enable <= CTRL_RESET;
      suspend_request <= CTRL_RESET;
      sleep_entry_guard <= CTRL_RESET;
    end else if (wr_ctrl) begin
      module_power_enable <= WDATA[BIT_POWER];
      suspend_request <= WDATA[BIT_SUSPEND];
      sleep_entry_guard <= WDATA[BIT_GUARD];
    end
  end

  // ********************************************************
  // readiness after power-off
  // ********************************************************

  // settle count reloads while on, runs down once off
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      settle <= SETTLE_RESET;
    end else if (module_power_enable) begin
      settle <= SETTLE_CYCLES;
    end else if (settle != SETTLE_RESET) begin
      settle <= settle - 4'h1;
    end
  end

  // busy while on or still settling
  assign next_not_ready = module_power_enable || (settle != SETTLE_RESET);

  // hardware-owned status, no write path
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      module_not_ready <= CTRL_RESET;
    end else begin
      module_not_ready <= next_not_ready;
    end
  end

  // ********************************************************
  // activity pending
  // ********************************************************

  // activity posting only runs on the ungated usb clock
  assign clk_run = module_power_enable && !suspend_request;

  // activity while off is ignored; edge wins over posting
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      activity_pending <= CTRL_RESET;
    end else if (module_power_enable && act_edge) begin
      activity_pending <= 1'b1;
    end else if (activity_pending && clk_run) begin
      activity_pending <= 1'b0;
    end else if (!module_power_enable) begin
      activity_pending <= 1'b0;
    end
  end

  // ********************************************************
  // interrupt status, mask and output
  // ********************************************************

  // events: activity posted, module became ready
  always_comb begin
    events = EV_RESET;
    events[EV_ACTIVITY] = activity_pending && clk_run
                          && !(act_edge && module_power_enable);
    events[EV_READY] = module_not_ready && !next_not_ready;
  end

  // sticky bits; a read clears, a new event wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= EV_RESET;
    end else if (rd_stat) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  // mask register, same layout as status
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask <= EV_RESET;
    end else if (wr_mask) begin
      mask <= WDATA[EV_W-1:0];
    end
  end

  // level interrupt from registered status
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= CTRL_RESET;
    end else begin
      IRQ <= |(status & mask);
    end
  end

  // ********************************************************
  // module side outputs
  // ********************************************************

  // off holds everything inactive; suspend gates clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      USB_CLK_EN <= CTRL_RESET;
      XCVR_LOWPOWER <= CTRL_RESET;
      PINS_OWNED <= CTRL_RESET;
      ANALOG_EN <= CTRL_RESET;
    end else begin
      USB_CLK_EN <= clk_run;
      XCVR_LOWPOWER <= module_power_enable && suspend_request;
      PINS_OWNED <= module_power_enable;
      ANALOG_EN <= module_power_enable;
    end
  end

  // sleep held off while guarded and activity outstanding
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SLEEP_BLOCK <= CTRL_RESET;
    end else begin
      SLEEP_BLOCK <= sleep_entry_guard && (act_sync || activity_pending);
    end
  end

  // ********************************************************
  // read data
  // ********************************************************

  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= RDATA_RESET;
    end else if (RD && hit(ADDR, OFF_CTRL)) begin
      RDATA <= ctrl_word(module_power_enable, suspend_request,
                         module_not_ready, sleep_entry_guard,
                         activity_pending);
    end else if (rd_stat) begin
      RDATA <= {30'h0, status};
    end else if (RD && hit(ADDR, OFF_MASK)) begin
      RDATA <= {30'h0, mask};
    end else begin
      RDATA <= RDATA_RESET;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // control read returns only the implemented bits
  property p_ctrl_reserved;
    RD && hit(ADDR, OFF_CTRL) |=> (RDATA[31:8] == 24'h0)
      && !RDATA[6] && !RDATA[5] && !RDATA[2];
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("reserved control bits read nonzero");

  // power bit reads back what was written
  property p_power_readback;
    wr_ctrl ##1 (RD && hit(ADDR, OFF_CTRL) && !wr_ctrl)
      |=> RDATA[BIT_POWER] == $past(WDATA[BIT_POWER], 2);
  endproperty
  a_power_readback: assert property (p_power_readback)
    else $error("power bit readback wrong");

  // off forces outputs inactive next cycle
  property p_off_inactive;
    !module_power_enable |=> !USB_CLK_EN && !PINS_OWNED
      && !ANALOG_EN && !XCVR_LOWPOWER;
  endproperty
  a_off_inactive: assert property (p_off_inactive)
    else $error("outputs active while module off");

  // suspend gates clock and parks transceiver
  property p_suspend;
    module_power_enable && suspend_request
      |=> !USB_CLK_EN && XCVR_LOWPOWER;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend not applied");

  // busy for the whole settle window after power-off
  sequence s_power_fall;
    $fell(module_power_enable);
  endsequence
  property p_settle_busy;
    s_power_fall |-> module_not_ready [*8];
  endproperty
  a_settle_busy: assert property (p_settle_busy)
    else $error("ready too early after power-off");

  // ready once off and settled
  property p_ready;
    !module_power_enable && settle == SETTLE_RESET
      |=> !module_not_ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("not ready when idle and settled");

  // writes to bit 3 cannot make the module look busy
  property p_busy_readonly;
    wr_ctrl && WDATA[BIT_NOT_READY] && !WDATA[BIT_POWER]
      && !module_power_enable && settle == SETTLE_RESET
      |=> !module_not_ready;
  endproperty
  a_busy_readonly: assert property (p_busy_readonly)
    else $error("write reached busy bit");

  // activity edge while on raises pending, then posts
  sequence s_activity;
    module_power_enable && act_edge;
  endsequence
  property p_pending_set;
    s_activity |=> activity_pending;
  endproperty
  a_pending_set: assert property (p_pending_set)
    else $error("activity not marked pending");

  property p_pending_post;
    activity_pending && clk_run && !act_edge
      |=> !activity_pending && status[EV_ACTIVITY];
  endproperty
  a_pending_post: assert property (p_pending_post)
    else $error("pending activity not posted");

  // guard blocks sleep, clear guard never blocks
  property p_guard_on;
    sleep_entry_guard && activity_pending |=> SLEEP_BLOCK;
  endproperty
  a_guard_on: assert property (p_guard_on)
    else $error("sleep not blocked");

  property p_guard_off;
    !sleep_entry_guard |=> !SLEEP_BLOCK;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("sleep blocked without guard");

  // event during clearing read survives
  property p_set_wins;
    rd_stat && events[EV_READY] |=> status[EV_READY];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost on status read");

  // masked status drives the interrupt one cycle on
  property p_irq;
    |(status & mask) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

endmodule // usb_power_control

// *** verif/usb_bus_model.sv ***
// behavioural model of the usb bus side raising activity at the transceiver
`timescale 1ns/1ps
module usb_bus_model (
  input wire logic CLK,
  input wire logic kick,
  output logic USB_ACTIVITY
);
  // ********************************************************
  // activity burst
  // ********************************************************
  logic [2:0] left;
  initial begin
    left = 3'h0;
  end
  // a kick starts a burst of four cycles; the line idles low otherwise
  always @(posedge CLK) begin
    if (kick && left == 3'h0) begin
      left <= 3'h4;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end
  assign USB_ACTIVITY = (left != 3'h0);
endmodule // usb_bus_model

// *** verif/usb_power_control_test.sv ***
// self-checking bench for the usb power control block
`timescale 1ns/1ps
module usb_power_control_test;
  import usb_power_control_pkg::*;
  // ********************************************************
  // signals
  // ********************************************************
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic kick = 1'b0;
  logic [31:0] RDATA;
  logic USB_ACTIVITY, USB_CLK_EN, XCVR_LOWPOWER, PINS_OWNED, ANALOG_EN, SLEEP_BLOCK, IRQ;
  int err_total = 0;
  int compares = 0;
  int p, s, g;
  logic [31:0] d;
  logic [1:0] ord [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  // 40 MHz clock
  always #12.5 CLK = ~CLK;
  usb_power_control uut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .USB_ACTIVITY(USB_ACTIVITY), .USB_CLK_EN(USB_CLK_EN),
    .XCVR_LOWPOWER(XCVR_LOWPOWER), .PINS_OWNED(PINS_OWNED), .ANALOG_EN(ANALOG_EN),
    .SLEEP_BLOCK(SLEEP_BLOCK), .IRQ(IRQ));
  usb_bus_model bus (.CLK(CLK), .kick(kick), .USB_ACTIVITY(USB_ACTIVITY));
  // ********************************************************
  // tasks
  // ********************************************************
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("Error at %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // read data are looked at in the one cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(RDATA, exp);
  endtask
  // write, then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] v,
                       input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(RDATA, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pulse();
    @(posedge CLK);
    kick <= 1'b1;
    @(posedge CLK);
    kick <= 1'b0;
  endtask
  // pin levels from the model state
  task automatic chk_out(input int sb, input int irq);
    check({26'h0, USB_CLK_EN, XCVR_LOWPOWER, PINS_OWNED, ANALOG_EN, SLEEP_BLOCK, IRQ},
      {26'h0, 1'(p & ~s), 1'(p & s), 1'(p), 1'(p), 1'(sb), 1'(irq)});
  endtask
  function automatic logic [31:0] ctrl_word(input int pend, input int busy);
    return {24'h0, 1'(pend), 2'h0, 1'(g), 1'(busy), 1'b0, 1'(s), 1'(p)};
  endfunction
  // ********************************************************
  // watchdog
  // ********************************************************
  initial begin
    #(25 * 5000);
    err_total++;
    report_and_stop();
  end
  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    void'($urandom(32'hbfe320d8));
    p = 0;
    s = 0;
    g = 0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    // reset values and the unmapped place
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h0);
    rd(OFF_MASK, 32'h0);
    chk_out(0, 0);
    wr(4'hc, $urandom);
    rd(4'hc, 32'h0);
    // every power and suspend mode, random upper bits, status bits set high
    for (int i = 0; i < 4; i++) begin
      // status bits 7 and 3 always written high so read-only handling is hit
      d = ($urandom & 32'hffff_fffc) | 32'h88 | ord[i];
      p = d[0];
      s = d[1];
      g = d[4];
      wr(OFF_CTRL, d);
      wait_cyc(2);
      chk_out(0, 0);
      rd(OFF_CTRL, ctrl_word(0, p));
    end
    d = $urandom;
    wr(OFF_MASK, d);
    rd(OFF_MASK, d & 32'h3);
    wr(OFF_MASK, 32'h1);
    // activity while running posts status and raises the interrupt
    s = 0;
    g = 0;
    wr_rd(OFF_CTRL, 32'h1, ctrl_word(0, 1));
    pulse();
    wait_cyc(10);
    chk_out(0, 1);
    rd(OFF_STAT, 32'h1);
    wait_cyc(3);
    chk_out(0, 0);
    rd(OFF_STAT, 32'h0);
    // activity in suspend stays pending and the guard blocks sleep
    s = 1;
    g = 1;
    wr(OFF_CTRL, 32'h13);
    pulse();
    wait_cyc(10);
    rd(OFF_CTRL, ctrl_word(1, 1));
    chk_out(1, 0);
    g = 0;
    wr(OFF_CTRL, 32'h3);
    wait_cyc(3);
    chk_out(0, 0);
    s = 0;
    wr(OFF_CTRL, 32'h1);
    wait_cyc(4);
    rd(OFF_CTRL, ctrl_word(0, 1));
    rd(OFF_STAT, 32'h1);
    // power off: busy during settling, then ready; only the control register is written
    p = 0;
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, ctrl_word(0, 1));
    wait_cyc(5);
    // status read lands on the ready event; the event must survive the clear
    rd(OFF_STAT, 32'h0);
    wait_cyc(5);
    rd(OFF_CTRL, 32'h0);
    chk_out(0, 0);
    rd(OFF_STAT, 32'h2);
    // activity while off is ignored
    pulse();
    wait_cyc(10);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h0);
    chk_out(0, 0);
    report_and_stop();
  end
endmodule // usb_power_control_test
